// ===== core/etl_pkg.sv
`default_nettype none
package etl_pkg;
   // register byte offsets
   localparam logic [4:0] ETL_OFS_CTRL = 5'h00;
   localparam logic [4:0] ETL_OFS_ACR  = 5'h04;
   localparam logic [4:0] ETL_OFS_DIVH = 5'h08;
   localparam logic [4:0] ETL_OFS_DIVL = 5'h0c;
   localparam logic [4:0] ETL_OFS_NVC  = 5'h10;
   localparam logic [4:0] ETL_OFS_NVH  = 5'h14;
   localparam logic [4:0] ETL_OFS_NVL  = 5'h18;
   // control bit positions
   localparam int ETL_B_LAT  = 0;
   localparam int ETL_B_PGM  = 1;
   localparam int ETL_B_ERA  = 2;
   localparam int ETL_B_BUSY = 3;
   localparam int ETL_B_LOCK = 7;
   // factory values of nonvolatile bytes
   localparam logic [7:0] ETL_NVC_SHIP = 8'hf0;
   localparam logic [7:0] ETL_NVH_SHIP = 8'h85;
   localparam logic [7:0] ETL_NVL_SHIP = 8'hac;
   localparam logic [7:0] ETL_ERASED   = 8'hff;
   // timing
   localparam int ETL_TICK_US    = 35;
   localparam int ETL_CLK_MHZ    = 100;
   localparam int ETL_PROG_US    = 10000;
   localparam int ETL_PROG_TICKS = (ETL_PROG_US + ETL_TICK_US - 1) / ETL_TICK_US;
   // latched target of a program or erase
   typedef enum logic [1:0] {ETL_T_NONE, ETL_T_CFG, ETL_T_DIVH, ETL_T_DIVL} etl_tgt_type;
   typedef enum logic [1:0] {ETL_ST_LOAD, ETL_ST_IDLE, ETL_ST_RUN, ETL_ST_HOLD} etl_st_type;
   // working divider
   typedef struct packed {
      logic        lock_dis;
      logic [10:0] div;
   } etl_div_type;
endpackage
`default_nettype wire

// ===== core/etl_loader.sv
// Functional notes
// RL1 - reset copies config byte into array config
// RL2 - config byte programmed via latch/enable sequence
// RL3 - config byte ships as f0, unprotected
// RL4 - two byte registers hold 11-bit divisor
// RL5 - reset loads divider from nonvolatile copies
// RL6 - divisor divides the selected reference clock
// RL7 - lock freezes divider, blocks nonvolatile copies
// RL8 - divisor writes need latch 0, lock-disable 1
// RL9 - software sets divisor to f*35us+0.5
// RL10 - software avoids programming with wrong divisor
// RL11 - divider copies programmed via latch sequence; code always blocks this
// RL12 - lock-disable 1 blocks divider copy programming
// RL13 - stored lock 0 locks divider forever
// RL14 - wait mode leaves sequence running
// RL15 - stop mode minimises power
// RL16 - software avoids stop during programming
// RL17 - stop with latch+enable pauses, restarts, blocks
// RL18 - stop otherwise aborts the sequence
// RL19 - latch bit captures target; held while enabled
// RL20 - enable powers array only with valid latch
// RL21 - tick on terminal count, then restart
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`default_nettype none
module etl_loader
   import etl_pkg::*;
#(
   parameter int PROG_TICKS = ETL_PROG_TICKS
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   input  wire logic        nv_por,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        stop_mode,
   output logic             timebase_tick,
   output logic             array_voltage_on,
   output logic             low_power,
   output logic             array_access_block,
   output logic      [7:0]  array_config_out
);
   // nonvolatile bytes, loaded with factory values only by power-on
   logic [7:0]  nvc_reg, nvc_next, nvh_reg, nvh_next, nvl_reg, nvl_next;
   // working and control state
   etl_st_type  st_reg, st_next;
   etl_div_type div_reg, div_next;
   etl_tgt_type tgt_reg, tgt_next;
   logic [7:0]  acr_reg, acr_next, ldat_reg, ldat_next;
   logic        lat_reg, lat_next, pgm_reg, pgm_next, era_reg, era_next;
   logic        wait_reg, wait_next, blk_reg, blk_next;
   logic        volt_reg, volt_next, tick_reg, tick_next, lp_reg, lp_next;
   logic [31:0] rd_reg, rd_next;
   logic [10:0] tb_reg, tb_next;
   logic [15:0] seq_reg, seq_next;
   logic        acc, wr, nv_div_blk, valid;

   // nonvolatile divider copies blocked from alteration, for every divider and lock value
   function automatic logic div_nv_blocked(input etl_div_type d, input logic [7:0] h);
      div_nv_blocked = d.lock_dis | h[ETL_B_LOCK]; // RL12
      div_nv_blocked = div_nv_blocked | ~d.lock_dis; // RL7
   endfunction

   assign acc     = (avs_read | avs_write) & ~wait_reg;
   assign wr      = acc & avs_write;
   assign nv_div_blk = div_nv_blocked(div_reg, nvh_reg);
   assign valid   = (tgt_reg == ETL_T_CFG) ||
                    ((tgt_reg != ETL_T_NONE) && !nv_div_blk);

   // nonvolatile storage commit at end of sequence
   always_comb begin
      nvc_next = nvc_reg;
      nvh_next = nvh_reg;
      nvl_next = nvl_reg;
      // commit only on the completing edge, not when stop or a clear wins
      if (st_reg == ETL_ST_RUN && seq_reg == 16'(PROG_TICKS) && valid &&
          pgm_reg && !stop_mode) begin
         unique case (tgt_reg)
            ETL_T_CFG:  nvc_next = era_reg ? ETL_ERASED : (nvc_reg & ldat_reg); // RL2
            ETL_T_DIVH: nvh_next = era_reg ? ETL_ERASED : (nvh_reg & ldat_reg); // RL11
            ETL_T_DIVL: nvl_next = era_reg ? ETL_ERASED : (nvl_reg & ldat_reg); // RL11
            ETL_T_NONE: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge nv_por) begin
      if (nv_por) begin
         nvc_reg <= ETL_NVC_SHIP; // RL3
         nvh_reg <= ETL_NVH_SHIP;
         nvl_reg <= ETL_NVL_SHIP;
      end else begin
         nvc_reg <= nvc_next;
         nvh_reg <= nvh_next;
         nvl_reg <= nvl_next;
      end
   end

   // bus, working registers and sequence
   always_comb begin
      st_next   = st_reg;
      div_next  = div_reg;
      acr_next  = acr_reg;
      tgt_next  = tgt_reg;
      ldat_next = ldat_reg;
      lat_next  = lat_reg;
      pgm_next  = pgm_reg;
      era_next  = era_reg;
      blk_next  = blk_reg;
      seq_next  = seq_reg;
      rd_next   = rd_reg;
      wait_next = 1'b1;
      lp_next   = stop_mode; // RL15
      // timebase, halted in stop
      tick_next = 1'b0;
      tb_next   = tb_reg + 11'h001;
      if (stop_mode) begin
         tb_next = 11'h000;
      end else if (tb_reg + 11'h001 >= div_reg.div) begin
         tb_next   = 11'h000; // RL21
         tick_next = 1'b1; // RL6
      end
      // bus answer one cycle after request
      if ((avs_read | avs_write) && wait_reg && st_reg != ETL_ST_LOAD) begin
         wait_next = 1'b0;
         rd_next   = 32'h0000_0000;
         unique case (avs_address)
            ETL_OFS_CTRL: begin
               rd_next[ETL_B_LAT]  = lat_reg;
               rd_next[ETL_B_PGM]  = pgm_reg;
               rd_next[ETL_B_ERA]  = era_reg;
               rd_next[ETL_B_BUSY] = st_reg != ETL_ST_IDLE;
            end
            ETL_OFS_ACR:  rd_next[7:0] = acr_reg;
            ETL_OFS_DIVH: rd_next[7:0] = {div_reg.lock_dis, 4'h0, div_reg.div[10:8]}; // RL4
            ETL_OFS_DIVL: rd_next[7:0] = div_reg.div[7:0];
            ETL_OFS_NVC:  rd_next[7:0] = nvc_reg;
            ETL_OFS_NVH:  rd_next[7:0] = nvh_reg;
            ETL_OFS_NVL:  rd_next[7:0] = nvl_reg;
            default:      rd_next = 32'h0000_0000;
         endcase
      end
      // register writes at the acknowledging edge
      if (wr) begin
         unique case (avs_address)
            ETL_OFS_CTRL: begin
               era_next = avs_writedata[ETL_B_ERA];
               if (avs_writedata[ETL_B_PGM]) begin
                  pgm_next = pgm_reg | (lat_reg & valid); // RL20
               end else begin
                  pgm_next = 1'b0;
               end
               if (avs_writedata[ETL_B_LAT]) begin
                  lat_next = 1'b1;
               end else if (!pgm_reg) begin
                  lat_next = 1'b0; // RL19
                  tgt_next = ETL_T_NONE;
               end
            end
            ETL_OFS_DIVH: begin
               if (!lat_reg && div_reg.lock_dis) begin // RL8
                  div_next.lock_dis  = avs_writedata[ETL_B_LOCK];
                  div_next.div[10:8] = avs_writedata[2:0];
               end
            end
            ETL_OFS_DIVL: begin
               if (!lat_reg && div_reg.lock_dis) begin // RL8
                  div_next.div[7:0] = avs_writedata[7:0];
               end
            end
            ETL_OFS_NVC, ETL_OFS_NVH, ETL_OFS_NVL: begin
               if (lat_reg && !pgm_reg) begin // RL19
                  ldat_next = avs_writedata[7:0];
                  tgt_next  = (avs_address == ETL_OFS_NVC) ? ETL_T_CFG :
                              (avs_address == ETL_OFS_NVH) ? ETL_T_DIVH : ETL_T_DIVL;
               end
            end
            default: ;
         endcase
      end
      // sequence; no wait input, so it runs on while the core waits
      unique case (st_reg)
         ETL_ST_LOAD: begin
            acr_next = nvc_reg; // RL1
            div_next = {nvh_reg[ETL_B_LOCK], nvh_reg[2:0], nvl_reg}; // RL5 RL13
            st_next  = ETL_ST_IDLE;
         end
         ETL_ST_IDLE: begin
            seq_next = 16'h0000;
            if (pgm_reg && stop_mode) begin
               st_next  = ETL_ST_HOLD; // RL17
               blk_next = 1'b1;
            end else if (pgm_reg) begin
               st_next = ETL_ST_RUN; // RL14
            end
         end
         ETL_ST_RUN: begin
            // stop as a level, so a stop just before the run is not missed
            if (stop_mode && lat_reg && pgm_reg) begin
               st_next  = ETL_ST_HOLD; // RL17
               blk_next = 1'b1;
            end else if (stop_mode || !pgm_reg) begin
               st_next  = ETL_ST_IDLE; // RL18
               pgm_next = 1'b0;
            end else if (seq_reg == 16'(PROG_TICKS)) begin
               st_next  = ETL_ST_IDLE;
               pgm_next = 1'b0;
               blk_next = 1'b0;
            end else if (tick_reg) begin
               seq_next = seq_reg + 16'h0001;
            end
         end
         ETL_ST_HOLD: begin
            seq_next = 16'h0000;
            if (!stop_mode) begin
               st_next = ETL_ST_RUN; // RL17
            end
         end
      endcase
      volt_next = (st_next == ETL_ST_RUN); // RL20
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg        <= ETL_ST_LOAD;
         div_reg       <= '0;
         acr_reg       <= 8'h00;
         tgt_reg       <= ETL_T_NONE;
         ldat_reg      <= 8'h00;
         lat_reg       <= 1'b0;
         pgm_reg       <= 1'b0;
         era_reg       <= 1'b0;
         blk_reg       <= 1'b0;
         seq_reg       <= 16'h0000;
         rd_reg        <= 32'h0000_0000;
         wait_reg      <= 1'b1;
         volt_reg      <= 1'b0;
         tick_reg      <= 1'b0;
         lp_reg        <= 1'b0;
         tb_reg        <= 11'h000;
      end else begin
         st_reg        <= st_next;
         div_reg       <= div_next;
         acr_reg       <= acr_next;
         tgt_reg       <= tgt_next;
         ldat_reg      <= ldat_next;
         lat_reg       <= lat_next;
         pgm_reg       <= pgm_next;
         era_reg       <= era_next;
         blk_reg       <= blk_next;
         seq_reg       <= seq_next;
         rd_reg        <= rd_next;
         wait_reg      <= wait_next;
         volt_reg      <= volt_next;
         tick_reg      <= tick_next;
         lp_reg        <= lp_next;
         tb_reg        <= tb_next;
      end
   end

   // outputs straight from flops
   assign avs_readdata       = rd_reg;
   assign avs_waitrequest    = wait_reg;
   assign timebase_tick      = tick_reg;
   assign array_voltage_on   = volt_reg;
   assign low_power          = lp_reg;
   assign array_access_block = blk_reg;
   assign array_config_out   = acr_reg;

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst || nv_por);

   a_acr_copy: assert property (st_reg == ETL_ST_LOAD && !sys_rst |=> // RL1
      acr_reg == $past(nvc_reg))
      else $error("config not copied at load");
   a_div_copy: assert property (st_reg == ETL_ST_LOAD && !sys_rst |=> // RL5 RL13
      div_reg.div == {$past(nvh_reg[2:0]), $past(nvl_reg)} &&
      div_reg.lock_dis == $past(nvh_reg[ETL_B_LOCK]))
      else $error("divider not copied at load");
   a_div_frozen: assert property (st_reg != ETL_ST_LOAD && !div_reg.lock_dis |=>
      $stable(div_reg)) // RL7
      else $error("locked divider changed");
   a_div_gate: assert property (st_reg != ETL_ST_LOAD && $past(st_reg) != ETL_ST_LOAD
      && $changed(div_reg) |-> // RL8
      !$past(lat_reg) && $past(div_reg.lock_dis) && $past(wr))
      else $error("divider written while gated");
   a_nvdiv_fixed: assert property ($stable(nvh_reg) && $stable(nvl_reg)) // RL12
      else $error("blocked divider copy altered");
   a_latch_hold: assert property (pgm_reg && lat_reg |=> lat_reg) // RL19
      else $error("latch cleared while enabled");
   a_pgm_gate: assert property ($rose(pgm_reg) |-> $past(lat_reg) && $past(valid)) // RL20
      else $error("enable set without valid latch");
   a_stop_pause: assert property (st_reg inside {ETL_ST_IDLE, ETL_ST_RUN} && // RL17
      stop_mode && lat_reg && pgm_reg |=> st_reg == ETL_ST_HOLD && !array_voltage_on)
      else $error("stop did not pause sequence");
   a_stop_abort: assert property (st_reg == ETL_ST_RUN && stop_mode && // RL18
      !(lat_reg && pgm_reg) |=> st_reg == ETL_ST_IDLE && !pgm_reg)
      else $error("stop did not abort sequence");
   a_tick_single: assert property (timebase_tick && div_reg.div > 11'h001 |=>
      !timebase_tick) // RL21
      else $error("tick longer than one cycle");
   a_low_power: assert property (1'b1 |=> low_power == $past(stop_mode)) // RL15
      else $error("stop not reflected");
   c_prog_run: cover property (st_reg == ETL_ST_RUN ##1 st_reg == ETL_ST_IDLE);
   c_stop_hold: cover property (st_reg == ETL_ST_HOLD ##1 st_reg == ETL_ST_RUN);
   c_div_write: cover property (wr && avs_address == ETL_OFS_DIVL && div_reg.lock_dis);
endmodule // etl_loader
`default_nettype wire

// ===== tb/tb_eeprom_timebase_config_loader.sv
`default_nettype none
module tb_eeprom_timebase_config_loader;
   import etl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        sys_clk;
   logic        sys_rst;
   logic        nv_por;
   logic [4:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        stop_mode;
   logic        timebase_tick;
   logic        array_voltage_on;
   logic        low_power;
   logic        array_access_block;
   logic [7:0]  array_config_out;
   int          fails;
   int          n_compared;
   int          cycles;
   logic [31:0] rd;

   etl_loader #(.PROG_TICKS(2)) i_etl_loader (
      .sys_clk            (sys_clk),
      .sys_rst            (sys_rst),
      .nv_por             (nv_por),
      .avs_address        (avs_address),
      .avs_read           (avs_read),
      .avs_write          (avs_write),
      .avs_writedata      (avs_writedata),
      .avs_readdata       (avs_readdata),
      .avs_waitrequest    (avs_waitrequest),
      .stop_mode          (stop_mode),
      .timebase_tick      (timebase_tick),
      .array_voltage_on   (array_voltage_on),
      .low_power          (low_power),
      .array_access_block (array_access_block),
      .array_config_out   (array_config_out)
   );

   // clock and hang guard
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one avalon access, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      avs_address   <= a;
      avs_writedata <= {24'h000000, d};
      avs_read      <= ~wr;
      avs_write     <= wr;
      // only the bench timeout ends this wait
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00);
      chk(rd, exp);
   endtask

   task automatic do_reset(input logic por);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      nv_por  <= por;
      repeat (6) @(posedge sys_clk);
      sys_rst <= 1'b0;
      nv_por  <= 1'b0;
   endtask

   // poll busy until the sequence is back to idle
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         bus(1'b0, ETL_OFS_CTRL, 8'h00);
         n++;
      end while (rd[ETL_B_BUSY] !== 1'b0 && n < 50);
      chk(n < 50, 1'b1);
   endtask

   task automatic s_reset();
      rchk(ETL_OFS_ACR, 32'h000000f0);
      chk(array_config_out, ETL_NVC_SHIP);
      rchk(ETL_OFS_NVC, 32'h000000f0);
      rchk(ETL_OFS_DIVH, 32'h00000085);
      rchk(ETL_OFS_DIVL, 32'h000000ac);
      rchk(ETL_OFS_NVH, 32'h00000085);
      rchk(5'h1c, 32'h00000000);
   endtask

   // divisor 4: ticks four cycles apart
   task automatic s_div();
      int n;
      bus(1'b1, ETL_OFS_DIVH, 8'h80);
      bus(1'b1, ETL_OFS_DIVL, 8'h04);
      rchk(ETL_OFS_DIVL, 32'h00000004);
      n = 0;
      do @(posedge sys_clk); while (timebase_tick !== 1'b1 && ++n < 50);
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (timebase_tick !== 1'b1 && n < 50);
      chk(n, 4);
   endtask

   task automatic s_prog();
      bus(1'b1, ETL_OFS_CTRL, 8'h01);
      bus(1'b1, ETL_OFS_DIVL, 8'h09);
      rchk(ETL_OFS_DIVL, 32'h00000004);
      bus(1'b1, ETL_OFS_NVC, 8'h3c);
      bus(1'b1, ETL_OFS_CTRL, 8'h03);
      repeat (2) @(posedge sys_clk);
      #1 chk(array_voltage_on, 1'b1);
      wait_idle();
      rchk(ETL_OFS_CTRL, 32'h00000001);
      rchk(ETL_OFS_NVC, 32'h00000030);
      bus(1'b1, ETL_OFS_CTRL, 8'h00);
   endtask

   task automatic s_gate();
      bus(1'b1, ETL_OFS_CTRL, 8'h02);
      rchk(ETL_OFS_CTRL, 32'h00000000);
      chk(array_voltage_on, 1'b0);
      bus(1'b1, ETL_OFS_CTRL, 8'h01);
      bus(1'b1, ETL_OFS_NVH, 8'h00);
      bus(1'b1, ETL_OFS_CTRL, 8'h03);
      rchk(ETL_OFS_CTRL, 32'h00000001);
      bus(1'b1, ETL_OFS_CTRL, 8'h00);
      rchk(ETL_OFS_NVH, 32'h00000085);
   endtask

   // erase held by stop from idle before it runs, started on release
   task automatic s_stop();
      bus(1'b1, ETL_OFS_CTRL, 8'h01);
      bus(1'b1, ETL_OFS_NVC, 8'h00);
      bus(1'b1, ETL_OFS_CTRL, 8'h07);
      stop_mode <= 1'b1;
      repeat (5) @(posedge sys_clk);
      #1 chk(array_voltage_on, 1'b0);
      chk(array_access_block, 1'b1);
      chk(low_power, 1'b1);
      chk(timebase_tick, 1'b0);
      @(posedge sys_clk);
      stop_mode <= 1'b0;
      wait_idle();
      chk(array_access_block, 1'b0);
      rchk(ETL_OFS_NVC, 32'h000000ff);
      bus(1'b1, ETL_OFS_CTRL, 8'h00);
   endtask

   task automatic s_lock();
      bus(1'b1, ETL_OFS_DIVH, 8'h00);
      rchk(ETL_OFS_DIVH, 32'h00000000);
      bus(1'b1, ETL_OFS_DIVL, 8'h08);
      rchk(ETL_OFS_DIVL, 32'h00000004);
      bus(1'b1, ETL_OFS_DIVH, 8'h80);
      rchk(ETL_OFS_DIVH, 32'h00000000);
      do_reset(1'b0);
      rchk(ETL_OFS_ACR, 32'h000000ff);
      rchk(ETL_OFS_DIVH, 32'h00000085);
   endtask

   task automatic finish_test();
      if (fails == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      fails = 0;
      n_compared = 0;
      cycles = 0;
      sys_rst = 1'b1;
      nv_por = 1'b1;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      stop_mode = 1'b0;
      do_reset(1'b1);
      s_reset();
      s_div();
      s_prog();
      s_gate();
      s_stop();
      s_lock();
      finish_test();
   end
endmodule // tb_eeprom_timebase_config_loader
`default_nettype wire
